// ### hw/supervisor_pkg.sv
// constants, field layouts and carrier types of the supply supervisor
package supervisor_pkg;
    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_NS = 25;
    localparam int MS_TICK_CYC = CLK_HZ / 1000;
    localparam int RST_TIMEOUT_MS = 145;
    localparam int RST_TIMEOUT_CYC = MS_TICK_CYC * RST_TIMEOUT_MS;
    localparam int CE_HOLD_NS = 12000;
    localparam int CE_HOLD_CYC = CE_HOLD_NS / CLK_NS;
    localparam int WD_TIMEOUT_MS = 1600;
    localparam int TEST_PERIOD_H = 24;
    localparam int TEST_PERIOD_MS = TEST_PERIOD_H * 3600 * 1000;
    localparam int TEST_PULSE_MS = 1300;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int ADDR_W = 4;
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    localparam int CTRL_WD_EN_BIT = 0;
    localparam int CTRL_TEST_BIT = 1;
    localparam logic CTRL_WD_EN_RST = 1'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic supply_low;
        logic early_low;
        logic backup_cell_input_above;
        logic supply_above_101;
        logic cell_low;
        logic cell_below_2v6;
        logic pf_below;
        logic pf_above_hys;
        logic kick_float;
        logic watchdog_kick_in;
        logic manual_reset_n;
        logic raw_select_n;
    } sense_t;

    typedef enum logic [1:0] {CE_PASS, CE_HOLD, CE_BLOCK} ce_state_t;
endpackage : supervisor_pkg

// ### hw/span_timer.sv
// saturating up-counter that flags when a terminal count is reached
`timescale 1ns/1ps
module span_timer #(
    parameter int W = 24
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic clr_i,
    input wire logic step_i,
    input wire logic [W-1:0] limit_i,
    output logic done_o
);
    logic [W-1:0] count;
    wire [W-1:0] next_count = W'(count + 1'b1);

    generate
        if (W < 2) begin : g_bad_width
            $error("span_timer width too small");
        end
    endgenerate

    always_ff @(posedge clk_sys_i) begin
        if (srst_i || clr_i) begin
            count <= '0;
            done_o <= 1'b0;
        end else if (step_i && !done_o) begin
            count <= next_count;
            done_o <= (next_count == limit_i);
        end
    end

    AST_TIMER_DONE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        done_o |-> count == limit_i)
        else $error("timer done without reaching its limit");
endmodule : span_timer

// ### hw/supply_supervisor.sv
// supply supervisor: reset timing, watchdog, backup switchover, cell test, select gating
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps

// What this block does
// - low supply and battery higher selects battery
// - supply above 1.01 battery returns main
// - reset low while fault, then full timeout
// - active-high reset mirrors the active-low one
// - watchdog output asserts after quiet timeout
// - watchdog count clears on reset or edge
// - watchdog output releases on edge or reset
// - floating kick input disables the watchdog
// - early warning low on low-line flag
// - cell test pulse 1.3s every 24h
// - low cell during test drops cell good
// - cell good low on backup or weak cell
// - backup output high while on battery
// - power fail output with hysteresis flags
// - gated select low outside reset, or held low into reset
// - held select ends at 12us or release
// - after hold, select stays high in reset
// - select high at reset stays high
// - reset outlasts manual release by 145ms
module supply_supervisor #(
    parameter int RST_CYC = supervisor_pkg::RST_TIMEOUT_CYC,
    parameter int WD_MS = supervisor_pkg::WD_TIMEOUT_MS,
    parameter int TEST_MS = supervisor_pkg::TEST_PERIOD_MS,
    parameter int PULSE_MS = supervisor_pkg::TEST_PULSE_MS,
    parameter int MS_CYC = supervisor_pkg::MS_TICK_CYC
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire supervisor_pkg::sense_t sense_i,
    output logic reset_n_o,
    output logic reset_o,
    output logic watchdog_expired_n_o,
    output logic early_warning_n_o,
    output logic cell_test_pulse_n_o,
    output logic cell_test_pulse_oe_o,
    output logic cell_good_o,
    output logic on_backup_power_o,
    output logic power_fail_n_o,
    output logic gated_select_n_o,
    input wire logic [supervisor_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [supervisor_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int HOLD_MAX = supervisor_pkg::CE_HOLD_CYC + 1;

    generate
        if (RST_CYC < 1 || RST_CYC >= (1 << 24) || WD_MS < 1 || WD_MS >= (1 << 16)
            || TEST_MS < 1 || TEST_MS >= (1 << 27) || PULSE_MS < 1
            || PULSE_MS >= (1 << 16) || MS_CYC < 2 || MS_CYC >= (1 << 16)) begin : g_bad
            $error("supply_supervisor parameter out of range");
        end
    endgenerate

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    supervisor_pkg::sense_t sync_a;
    supervisor_pkg::sense_t s;
    logic kick_q;

    always_ff @(posedge clk_sys_i) begin
        sync_a <= sense_i;
        s <= sync_a;
        kick_q <= s.watchdog_kick_in;
    end

    wire kick_edge = s.watchdog_kick_in ^ kick_q;

    // ****************************************************************
    // millisecond tick
    // ****************************************************************
    logic [15:0] ms_div;
    logic ms_tick;
    wire div_wrap = (ms_div == 16'(MS_CYC - 1));

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ms_div <= 16'h0000;
            ms_tick <= 1'b0;
        end else begin
            ms_div <= div_wrap ? 16'h0000 : 16'(ms_div + 1'b1);
            ms_tick <= div_wrap;
        end
    end

    // ****************************************************************
    // reset generation
    // ****************************************************************
    logic rst_active;
    logic rst_done;
    wire rst_cond = s.supply_low || !s.manual_reset_n;
    // the timer restarts whenever a fault reappears, so a bouncing button
    // keeps reset asserted without any debounce logic
    wire next_rst_active = rst_cond ? 1'b1 : (rst_done ? 1'b0 : rst_active);

    span_timer #(.W(24)) u_rst_timer (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .clr_i(rst_cond || !rst_active),
        .step_i(1'b1),
        .limit_i(24'(RST_CYC)),
        .done_o(rst_done)
    );

    // ****************************************************************
    // watchdog
    // ****************************************************************
    logic wd_en;
    logic wd_done;
    wire wd_on = wd_en && !s.kick_float;
    wire wd_clr = !wd_on || kick_edge || rst_active;

    // one extra tick because the first millisecond is only partly seen
    span_timer #(.W(16)) u_wd_timer (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .clr_i(wd_clr),
        .step_i(ms_tick),
        .limit_i(16'(WD_MS + 1)),
        .done_o(wd_done)
    );

    // ****************************************************************
    // periodic cell test
    // ****************************************************************
    logic test_run;
    logic test_fail;
    logic test_req;
    logic period_done;
    logic pulse_done;
    wire test_start = !test_run && (period_done || test_req);
    wire next_test_run = test_start ? 1'b1 : (pulse_done ? 1'b0 : test_run);

    span_timer #(.W(27)) u_period_timer (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .clr_i(test_start),
        .step_i(ms_tick),
        .limit_i(27'(TEST_MS)),
        .done_o(period_done)
    );

    span_timer #(.W(16)) u_pulse_timer (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .clr_i(!test_run),
        .step_i(ms_tick),
        .limit_i(16'(PULSE_MS)),
        .done_o(pulse_done)
    );

    // ****************************************************************
    // backup switchover and status outputs
    // ****************************************************************
    logic on_backup;
    wire next_backup = s.supply_above_101 ? 1'b0
        : ((rst_active && s.backup_cell_input_above) ? 1'b1 : on_backup);
    wire cell_fail_now = test_run && s.cell_below_2v6;
    wire next_fail = cell_fail_now ? 1'b1 : (test_start ? 1'b0 : test_fail);
    wire next_good = !(on_backup || s.cell_low || next_fail);
    wire next_pf_n = s.pf_below ? 1'b0 : (s.pf_above_hys ? 1'b1 : power_fail_n_o);
    wire next_wdo_n = (rst_active || wd_clr) ? 1'b1
        : (wd_done ? 1'b0 : watchdog_expired_n_o);

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rst_active <= 1'b1;
            on_backup <= 1'b0;
            test_run <= 1'b0;
            test_fail <= 1'b0;
            reset_n_o <= 1'b0;
            reset_o <= 1'b1;
            watchdog_expired_n_o <= 1'b1;
            early_warning_n_o <= 1'b0;
            cell_test_pulse_n_o <= 1'b0;
            cell_test_pulse_oe_o <= 1'b0;
            cell_good_o <= 1'b0;
            on_backup_power_o <= 1'b0;
            power_fail_n_o <= 1'b1;
        end else begin
            rst_active <= next_rst_active;
            on_backup <= next_backup;
            test_run <= next_test_run;
            test_fail <= next_fail;
            reset_n_o <= !rst_active;
            reset_o <= rst_active;
            watchdog_expired_n_o <= next_wdo_n;
            // held low until reset releases, so it deasserts no earlier than the same cycle as reset_n_o
            early_warning_n_o <= !(s.early_low || rst_active);
            cell_test_pulse_n_o <= 1'b0;
            cell_test_pulse_oe_o <= next_test_run;
            cell_good_o <= next_good;
            on_backup_power_o <= next_backup;
            power_fail_n_o <= next_pf_n;
        end
    end

    // ****************************************************************
    // chip-select gating
    // ****************************************************************
    supervisor_pkg::ce_state_t ce_state;
    supervisor_pkg::ce_state_t next_ce;
    logic hold_done;
    logic next_gated;

    span_timer #(.W(10)) u_hold_timer (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .clr_i(ce_state != supervisor_pkg::CE_HOLD),
        .step_i(1'b1),
        .limit_i(10'(supervisor_pkg::CE_HOLD_CYC)),
        .done_o(hold_done)
    );

    always_comb begin
        next_ce = ce_state;
        next_gated = 1'b1;
        case (ce_state)
            supervisor_pkg::CE_PASS: begin
                if (!rst_active) begin
                    next_gated = s.raw_select_n;
                end else if (!s.raw_select_n) begin
                    next_ce = supervisor_pkg::CE_HOLD;
                    next_gated = 1'b0;
                end else begin
                    next_ce = supervisor_pkg::CE_BLOCK;
                end
            end
            supervisor_pkg::CE_HOLD: begin
                if (s.raw_select_n || hold_done) begin
                    next_ce = supervisor_pkg::CE_BLOCK;
                end else begin
                    next_gated = 1'b0;
                end
            end
            supervisor_pkg::CE_BLOCK: begin
                if (!rst_active) begin
                    next_ce = supervisor_pkg::CE_PASS;
                end
            end
            default: begin
                next_ce = supervisor_pkg::CE_BLOCK;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ce_state <= supervisor_pkg::CE_BLOCK;
            gated_select_n_o <= 1'b1;
        end else begin
            ce_state <= next_ce;
            gated_select_n_o <= next_gated;
        end
    end

    // ****************************************************************
    // register slave
    // ****************************************************************
    logic [supervisor_pkg::ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire wr_ctrl = (wr_addr == supervisor_pkg::CTRL_ADDR);
    wire wr_known = wr_ctrl || (wr_addr == supervisor_pkg::STATUS_ADDR);
    wire rd_ctrl = (s_axi_araddr == supervisor_pkg::CTRL_ADDR);
    wire rd_stat = (s_axi_araddr == supervisor_pkg::STATUS_ADDR);
    wire [31:0] ctrl_word = {31'h0, wd_en};
    wire [31:0] stat_word = {22'h0, ce_state, test_fail, test_run, cell_good_o,
        early_warning_n_o, power_fail_n_o, watchdog_expired_n_o, on_backup, rst_active};
    wire [31:0] rd_word = rd_ctrl ? ctrl_word : (rd_stat ? stat_word : 32'h0);

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= supervisor_pkg::RESP_OKAY;
            wr_addr <= '0;
            wr_data <= 32'h0;
            wr_strb <= 4'h0;
            wd_en <= supervisor_pkg::CTRL_WD_EN_RST;
            test_req <= 1'b0;
        end else begin
            test_req <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                wr_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? supervisor_pkg::RESP_OKAY
                    : supervisor_pkg::RESP_SLVERR;
                if (wr_ctrl && wr_strb[0]) begin
                    wd_en <= wr_data[supervisor_pkg::CTRL_WD_EN_BIT];
                    test_req <= wr_data[supervisor_pkg::CTRL_TEST_BIT];
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= supervisor_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (rd_ctrl || rd_stat) ? supervisor_pkg::RESP_OKAY
                : supervisor_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    AST_BACKUP_SELECT: assert property (
        rst_active && s.backup_cell_input_above && !s.supply_above_101 |=> on_backup_power_o)
        else $error("battery not selected during reset");
    AST_MAIN_RETURN: assert property (
        s.supply_above_101 |=> !on_backup_power_o)
        else $error("main supply not restored");
    AST_RESET_ASSERT: assert property (
        rst_cond |=> ##1 !reset_n_o)
        else $error("reset not asserted on fault");
    AST_RESET_POLARITY: assert property (
        reset_o == !reset_n_o)
        else $error("reset outputs disagree");
    AST_RESET_TIMEOUT: assert property (
        $fell(rst_cond) |=> rst_active [*8])
        else $error("reset released early");
    AST_WD_RELEASE: assert property (
        kick_edge |=> watchdog_expired_n_o)
        else $error("watchdog output not released on edge");
    AST_WD_QUIET: assert property (
        s.kick_float |=> watchdog_expired_n_o)
        else $error("watchdog active while input floats");
    AST_EARLY_WARN: assert property (
        s.early_low |=> !early_warning_n_o)
        else $error("early warning missing");
    AST_TEST_PULSE: assert property (
        $rose(test_run) |-> cell_test_pulse_oe_o && !cell_test_pulse_n_o)
        else $error("cell test pulse not driven");
    AST_CELL_GOOD: assert property (
        on_backup || cell_fail_now |=> !cell_good_o)
        else $error("cell good high on backup or failed test");
    AST_POWER_FAIL: assert property (
        s.pf_below |=> !power_fail_n_o)
        else $error("power fail not flagged");
    AST_CE_BLOCKED: assert property (
        rst_active && ce_state == supervisor_pkg::CE_BLOCK |=> gated_select_n_o)
        else $error("select passed during reset");
    AST_CE_HOLD_END: assert property (
        $rose(ce_state == supervisor_pkg::CE_HOLD)
        |-> ##[1:HOLD_MAX] ce_state != supervisor_pkg::CE_HOLD)
        else $error("select hold overran");
    AST_CE_STAY: assert property (
        ce_state == supervisor_pkg::CE_BLOCK && rst_active
        |=> ce_state == supervisor_pkg::CE_BLOCK)
        else $error("select left blocked state during reset");
endmodule : supply_supervisor

// ### bench/host_model.sv
// host side model: watchdog kick driver and memory select requester
`timescale 1ns/1ps
module host_model (
    input wire logic clk_sys_i,
    input wire logic [1:0] kick_mode_i,
    input wire logic sel_req_i,
    output logic kick_o,
    output logic float_o,
    output logic raw_select_n_o
);
    logic [1:0] div = 2'h0;
    logic kick_q = 1'b0;
    logic rel_q = 1'b0;
    // ****
    // kick: 0 holds still, 1 toggles every fourth cycle, 2 releases the line
    // ****
    always @(posedge clk_sys_i) begin
        div <= div + 2'h1;
        rel_q <= (kick_mode_i == 2'h2);
        if (kick_mode_i == 2'h1 && div == 2'h3) begin
            kick_q <= ~kick_q;
        end else if (kick_mode_i == 2'h2 && !rel_q) begin
            // a released line drifts once off its last level, then stays quiet
            kick_q <= ~kick_q;
        end
    end
    assign kick_o = kick_q;
    assign float_o = (kick_mode_i == 2'h2);
    assign raw_select_n_o = ~sel_req_i;
endmodule : host_model

// ### bench/tb.sv
// self-checking bench for the supply supervisor
`timescale 1ns/1ps
module tb;
    localparam int RC = 20;
    localparam int MC = 4;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    supervisor_pkg::sense_t sn = 12'h002;
    supervisor_pkg::sense_t sense_w;
    logic [1:0] kick_mode = 2'h1;
    logic sel_req = 1'b0;
    logic kick, flt, rsel_n;
    logic rst_n, rst, wd_n, ew_n, tp_n, tp_oe, cg, bkp, pf_n, gsel_n;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    int miscompares = 0;
    int cmp_count = 0;
    int n;
    int per;

    always #12.5 clk_sys_i = ~clk_sys_i;
    assign sense_w = {sn[11:4], flt, kick, sn.manual_reset_n, rsel_n};

    host_model host (.clk_sys_i(clk_sys_i), .kick_mode_i(kick_mode), .sel_req_i(sel_req),
        .kick_o(kick), .float_o(flt), .raw_select_n_o(rsel_n));

    supply_supervisor #(.RST_CYC(RC), .WD_MS(3), .TEST_MS(5), .PULSE_MS(2), .MS_CYC(MC)) dut (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .sense_i(sense_w), .reset_n_o(rst_n),
        .reset_o(rst), .watchdog_expired_n_o(wd_n), .early_warning_n_o(ew_n),
        .cell_test_pulse_n_o(tp_n), .cell_test_pulse_oe_o(tp_oe), .cell_good_o(cg),
        .on_backup_power_o(bkp), .power_fail_n_o(pf_n), .gated_select_n_o(gsel_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // ****
    // shared tasks
    // ****
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        cmp_count++;
        if (g < lo || g > hi) begin
            miscompares++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : chk_rng

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
    endtask : cyc

    // bounded wait; n holds the edges it took
    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge clk_sys_i);
            n++;
        end
        if (s !== v) chk("level wait", v, s);
    endtask : wait_lvl

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        resp = bresp;
    endtask : wr

    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk_sys_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        resp = rresp;
        rd = rdata;
    endtask : rd_reg

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    // ****
    // scenarios
    // ****
    initial begin
        cyc(12);
        srst_i <= 1'b0;
        cyc(1);
        chk("pins at reset", 32'h0C3, {rst_n, rst, wd_n, ew_n, tp_oe, cg, bkp, pf_n, gsel_n});
        wait_lvl(rst_n, 1'b1, RC + 12);
        chk_rng("first release", RC, RC + 12, n);
        cyc(60);
        chk("wd kicked", 1, wd_n);
        kick_mode <= 2'h0;
        wait_lvl(wd_n, 1'b0, 40);
        chk_rng("wd span", 3 * MC, 5 * MC + 6, n);
        kick_mode <= 2'h1;
        wait_lvl(wd_n, 1'b1, 12);
        chk("wd after kick", 1, wd_n);
        kick_mode <= 2'h2;
        cyc(40);
        chk("wd floating", 1, wd_n);
        kick_mode <= 2'h0;
        wait_lvl(wd_n, 1'b0, 40);
        sn.manual_reset_n <= 1'b0;
        wait_lvl(rst_n, 1'b0, 8);
        cyc(2);
        chk("wd in reset", 1, wd_n);
        chk("reset_o", 1, rst);
        kick_mode <= 2'h1;
        cyc(30);
        chk("held reset", 0, rst_n);
        sn.manual_reset_n <= 1'b1;
        wait_lvl(rst_n, 1'b1, RC + 12);
        chk_rng("manual release", RC, RC + 8, n);
        sn.supply_low <= 1'b1;
        sn.backup_cell_input_above <= 1'b1;
        wait_lvl(rst_n, 1'b0, 8);
        cyc(3);
        chk("backup on", 1, bkp);
        chk("good on backup", 0, cg);
        sn.supply_above_101 <= 1'b1;
        cyc(4);
        chk("backup off", 0, bkp);
        sn.supply_low <= 1'b0;
        sn.backup_cell_input_above <= 1'b0;
        sn.supply_above_101 <= 1'b0;
        wait_lvl(rst_n, 1'b1, RC + 12);
        chk_rng("supply release", RC, RC + 8, n);
        chk("backup idle", 0, bkp);
        sn.early_low <= 1'b1;
        cyc(4);
        chk("early warning", 32'h1, {ew_n, rst_n});
        sn.early_low <= 1'b0;
        sn.pf_below <= 1'b1;
        cyc(4);
        chk("pf low", 32'h1, {pf_n, ew_n});
        sn.pf_below <= 1'b0;
        cyc(4);
        chk("pf hysteresis", 0, pf_n);
        sn.pf_above_hys <= 1'b1;
        cyc(4);
        chk("pf high", 1, pf_n);
        sn.pf_above_hys <= 1'b0;
        sel_req <= 1'b1;
        cyc(4);
        chk("select pass", 0, gsel_n);
        sn.supply_low <= 1'b1;
        wait_lvl(rst_n, 1'b0, 8);
        cyc(400);
        chk("select held", 0, gsel_n);
        cyc(100);
        chk("hold expired", 1, gsel_n);
        sel_req <= 1'b0;
        cyc(4);
        sel_req <= 1'b1;
        cyc(4);
        chk("after hold", 1, gsel_n);
        sn.supply_low <= 1'b0;
        wait_lvl(rst_n, 1'b1, RC + 12);
        cyc(4);
        chk("select back", 0, gsel_n);
        sn.supply_low <= 1'b1;
        wait_lvl(rst_n, 1'b0, 8);
        cyc(50);
        sel_req <= 1'b0;
        cyc(4);
        chk("hold cut short", 1, gsel_n);
        sn.supply_low <= 1'b0;
        wait_lvl(rst_n, 1'b1, RC + 12);
        sn.supply_low <= 1'b1;
        wait_lvl(rst_n, 1'b0, 8);
        sel_req <= 1'b1;
        cyc(6);
        chk("idle at reset", 1, gsel_n);
        sel_req <= 1'b0;
        sn.supply_low <= 1'b0;
        wait_lvl(rst_n, 1'b1, RC + 12);
        rd_reg(supervisor_pkg::STATUS_ADDR);
        chk("status", {6'h3C, supervisor_pkg::RESP_OKAY}, {rd[5:0], resp});
        rd_reg(4'h8);
        chk("unmapped read", 32'h0, rd);
        chk("unmapped read resp", supervisor_pkg::RESP_SLVERR, resp);
        wr(4'hC, 32'h0);
        chk("unmapped write", supervisor_pkg::RESP_SLVERR, resp);
        wr(supervisor_pkg::STATUS_ADDR, 32'hFFFFFFFF);
        chk("status write", supervisor_pkg::RESP_OKAY, resp);
        sn.cell_below_2v6 <= 1'b1;
        wr(supervisor_pkg::CTRL_ADDR, 32'h3);
        // a periodic test may already be running; measure only a whole pulse
        wait_lvl(tp_oe, 1'b0, 20);
        wait_lvl(tp_oe, 1'b1, 30);
        chk("pulse low", 0, tp_n);
        wait_lvl(tp_oe, 1'b0, 20);
        chk_rng("pulse width", MC, 3 * MC, n);
        cyc(2);
        chk("cell failed", 0, cg);
        sn.cell_below_2v6 <= 1'b0;
        wait_lvl(tp_oe, 1'b1, 40);
        wait_lvl(tp_oe, 1'b0, 20);
        per = n;
        cyc(3);
        chk("cell good", 1, cg);
        wait_lvl(tp_oe, 1'b1, 40);
        chk_rng("test period", 5 * MC - 4, 5 * MC + 4, per + n + 3);
        conclude();
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        miscompares++;
        conclude();
    end
endmodule : tb
